// ---- test/lbrc_chk.sv ----
// Port assertions for the breathing ramp block
`include "lbrc_map.vh"
module lbrc_chk (
    input wire core_clk_in,
    input wire nrst_in,
    input wire [7:0] addr_in,
    input wire [31:0] wdata_in,
    input wire [3:0] wbe_in,
    input wire wr_in,
    input wire rd_in,
    input wire [31:0] rdata_out,
    input wire pwm_out,
    input wire [7:0] duty_out,
    input wire falling_out,
    input wire period_end_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] mode_q;
    logic [1:0] res_q;
    logic [7:0] prev_q;
    logic [7:0] diff;
    logic [7:0] lim;
    always @(posedge core_clk_in)
    begin
        prev_q <= duty_out;
        if (!nrst_in)
        begin
            mode_q <= 2'h0;
            res_q <= 2'h0;
        end
        else if (wr_in && addr_in == `LBRC_OFF_CTRL)
        begin
            mode_q <= wdata_in[1:0];
            res_q <= wdata_in[5:4];
        end
    end
    assign diff = (duty_out > prev_q) ? duty_out - prev_q : prev_q - duty_out;
    assign lim = (res_q == 2'h1) ? 8'h08 : (res_q == 2'h2) ? 8'h04 : 8'h10;
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (!nrst_in);
    AST_RDATA_IDLE: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data outside answer cycle");
    AST_UNMAPPED: assert property ($past(rd_in) && $past(addr_in) > 8'h0C |-> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    AST_BOUNDS_RSVD: assert property ($past(rd_in) && $past(addr_in) == 8'h04 |-> rdata_out[31:16] == 16'h0)
        else $error("bounds upper half not zero");
    AST_PE_PULSE: assert property (period_end_out |=> !period_end_out)
        else $error("period end longer than one cycle");
    AST_OFF: assert property ((mode_q == 2'h0) [*3] |-> !pwm_out && duty_out == 8'h00)
        else $error("output active in off mode");
    AST_ON: assert property ((mode_q == 2'h3) [*3] |-> pwm_out)
        else $error("output low in on mode");
    AST_STEP: assert property ($changed(duty_out) && mode_q == 2'h1 && $past(mode_q) == 2'h1 && $stable(res_q) |-> diff <= lim)
        else $error("duty step too large");
    AST_DUTY_AT_END: assert property ($changed(duty_out) && mode_q == 2'h1 && $past(mode_q) == 2'h1 |-> $past(period_end_out) || $past(period_end_out, 2))
        else $error("duty changed away from period end");
endmodule

// ---- test/lbrc_led_model.sv ----
// LED model that counts lit cycles in each PWM period
module lbrc_led_model (
    input wire logic core_clk_in,
    input wire logic pwm_in,
    input wire logic period_end_in,
    output logic [15:0] lit_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] cnt_q = 16'h0000;
    initial lit_out = 16'h0000;
    always @(posedge core_clk_in)
    begin
        cnt_q <= period_end_in ? 16'h0000 : cnt_q + {15'h0000, pwm_in};
        if (period_end_in)
            lit_out <= cnt_q + {15'h0000, pwm_in};
    end
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the breathing ramp block
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic [3:0] wbe_in = 4'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    wire [31:0] rdata_out;
    wire pwm_out;
    wire [7:0] duty_out;
    wire falling_out;
    wire period_end_out;
    logic [15:0] lit;
    logic [31:0] d;
    int error_cnt = 0;
    int check_count = 0;
    int n;
    always #2 core_clk_in = ~core_clk_in;
    lbrc_ramp dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wbe_in(wbe_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pwm_out(pwm_out),
        .duty_out(duty_out), .falling_out(falling_out), .period_end_out(period_end_out));
    lbrc_led_model led (.core_clk_in(core_clk_in), .pwm_in(pwm_out), .period_end_in(period_end_out), .lit_out(lit));
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] be);
        addr_in <= a;
        wdata_in <= v;
        wbe_in <= be;
        wr_in <= 1'b1;
        @(posedge core_clk_in);
        wr_in <= 1'b0;
        @(posedge core_clk_in);
    endtask
    task automatic rd(input logic [7:0] a);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge core_clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    task automatic wait_pe(input int k);
        repeat (k)
        begin
            @(posedge core_clk_in);
            while (period_end_out !== 1'b1)
                @(posedge core_clk_in);
        end
    endtask
    task automatic t_bounds;
        wr(8'h04, 32'h8010, 4'h3);
        rd(8'h04);
        `CHK(d, 32'h0)
        wr(8'h00, 32'h21, 4'h0);
        wait_pe(1);
        rd(8'h04);
        `CHK(d, 32'h8010)
        wr(8'h04, 32'hFF22, 4'h1);
        wait_pe(1);
        rd(8'h04);
        `CHK(d, 32'h8022)
        rd(8'h20);
        `CHK(d, 32'h0)
        $display("t_bounds done");
    endtask
    task automatic t_commit;
        wr(8'h08, 32'h002000, 4'h0);
        wr(8'h0C, 32'hFFFFFFFF, 4'h0);
        wait_pe(2);
        rd(8'h0C);
        `CHK(d, 32'h0)
        wr(8'h00, 32'h61, 4'h0);
        wait_pe(1);
        rd(8'h0C);
        `CHK(d, 32'hFFFFFFFF)
        rd(8'h08);
        `CHK(d, 32'h002000)
        rd(8'h00);
        `CHK(d[6], 1'b0)
        $display("t_commit done");
    endtask
    task automatic t_sym;
        wr(8'h04, 32'hFF00, 4'h3);
        wr(8'h0C, 32'h000000F2, 4'h0);
        wait_pe(1);
        wr(8'h00, 32'h00, 4'h0);
        wr(8'h00, 32'h55, 4'h0);
        wait_pe(2);
        @(posedge core_clk_in);
        #1;
        `CHK(duty_out, 8'h0A)
        wait_pe(12);
        @(posedge core_clk_in);
        #1;
        `CHK(duty_out, 8'h28)
        $display("t_sym done");
    endtask
    task automatic t_breathe;
        wr(8'h04, 32'h2008, 4'h3);
        wait_pe(1);
        wr(8'h00, 32'h00, 4'h0);
        wr(8'h00, 32'h21, 4'h0);
        while (duty_out < 8'h20)
            wait_pe(1);
        #1;
        `CHK(duty_out, 8'h20)
        n = 1;
        while (falling_out !== 1'b1)
        begin
            wait_pe(1);
            n++;
            #1;
        end
        `CHK(n, 3)
        wait (duty_out != 8'h20);
        #1;
        `CHK(duty_out, 8'h1C)
        wait (falling_out === 1'b0);
        #1;
        `CHK(duty_out, 8'h08)
        $display("t_breathe done");
    endtask
    task automatic t_blink;
        wr(8'h04, 32'h0030, 4'h1);
        wr(8'h08, 32'h000001, 4'h0);
        wr(8'h00, 32'h42, 4'h0);
        wait_pe(3);
        #1;
        `CHK(duty_out, 8'h30)
        `CHK(lit, 16'h0060)
        $display("t_blink done");
    endtask
    task automatic t_on;
        wr(8'h00, 32'h03, 4'h0);
        repeat (4) @(posedge core_clk_in);
        #1;
        `CHK(pwm_out, 1'b1)
        wr(8'h00, 32'h00, 4'h0);
        repeat (4) @(posedge core_clk_in);
        #1;
        `CHK({pwm_out, duty_out}, 9'h000)
        $display("t_on done");
    endtask
    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        @(posedge core_clk_in);
        t_bounds();
        t_commit();
        t_breathe();
        t_blink();
        t_sym();
        t_on();
        end_of_test();
    end
    initial
    begin
        #300000;
        error_cnt++;
        end_of_test();
    end
endmodule
bind lbrc_ramp lbrc_chk chk (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wbe_in(wbe_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .pwm_out(pwm_out), .duty_out(duty_out), .falling_out(falling_out), .period_end_out(period_end_out));

// ---- verilog/lbrc_map.vh ----
// Register offsets, field positions and reset values of the breathing ramp block
`ifndef LBRC_MAP_VH
`define LBRC_MAP_VH
`define LBRC_ADDR_W 8
`define LBRC_OFF_BOUNDS 8'h04
`define LBRC_OFF_DWELL 8'h08
`define LBRC_OFF_STEPS 8'h0C
`define LBRC_OFF_CTRL 8'h00
`define LBRC_UPPER_MSB 15
`define LBRC_UPPER_LSB 8
`define LBRC_LOWER_MSB 7
`define LBRC_LOWER_LSB 0
`define LBRC_TOP_MSB 23
`define LBRC_TOP_LSB 12
`define LBRC_BOT_MSB 11
`define LBRC_BOT_LSB 0
`define LBRC_CTRL_MODE_MSB 1
`define LBRC_CTRL_MODE_LSB 0
`define LBRC_CTRL_MIRROR 2
`define LBRC_CTRL_RES_MSB 5
`define LBRC_CTRL_RES_LSB 4
`define LBRC_CTRL_COMMIT 6
`define LBRC_MODE_OFF 2'h0
`define LBRC_MODE_BREATHE 2'h1
`define LBRC_MODE_BLINK 2'h2
`define LBRC_MODE_ON 2'h3
`define LBRC_RES_8 2'h0
`define LBRC_RES_7 2'h1
`define LBRC_RES_6 2'h2
`define LBRC_BOUNDS_RST 16'h0000
`define LBRC_DWELL_RST 24'h000000
`define LBRC_STEPS_RST 32'h00000000
`endif

// ---- verilog/lbrc_pwm_period.v ----
// PWM period counter that marks the last cycle of each period
`include "lbrc_map.vh"
module lbrc_pwm_period (
    input wire core_clk_in,
    input wire nrst_in,
    input wire run_in,
    input wire [1:0] res_in,
    input wire [11:0] prescale_in,
    input wire use_prescale_in,
    output reg period_end_out,
    output reg [7:0] count_out
);
    reg [11:0] pre_q;
    reg [7:0] top;
    wire tick;

    always @*
    begin
        case (res_in)
            `LBRC_RES_7: top = 8'h7F;
            `LBRC_RES_6: top = 8'h3F;
            default: top = 8'hFF;
        endcase
    end

    // Blink prescaler divides the base clock into count ticks
    assign tick = !use_prescale_in || (pre_q >= prescale_in);

    always @(posedge core_clk_in)
    begin
        if (!nrst_in || !run_in)
        begin
            pre_q <= 12'h000;
            count_out <= 8'h00;
            period_end_out <= 1'b0;
        end
        else
        begin
            period_end_out <= 1'b0;
            pre_q <= tick ? 12'h000 : pre_q + 12'h001;
            if (tick)
            begin
                if (count_out >= top)
                begin
                    count_out <= 8'h00;
                    period_end_out <= 1'b1;
                end
                else
                begin
                    count_out <= count_out + 8'h01;
                end
            end
        end
    end
endmodule

// ---- verilog/lbrc_ramp.v ----
// Duty-cycle ramp engine with limit, dwell and step registers
`include "lbrc_map.vh"
module lbrc_ramp (
    input wire core_clk_in,
    input wire nrst_in,
    input wire [7:0] addr_in,
    input wire [31:0] wdata_in,
    input wire [3:0] wbe_in,
    input wire wr_in,
    input wire rd_in,
    output reg [31:0] rdata_out,
    output reg pwm_out,
    output reg [7:0] duty_out,
    output wire falling_out,
    output wire period_end_out
);
    reg [15:0] bounds_q;
    reg [15:0] bounds_hold_q;
    reg [23:0] dwell_q;
    reg [23:0] dwell_hold_q;
    reg [31:0] steps_q;
    reg [31:0] steps_hold_q;
    reg [1:0] mode_q;
    reg mirror_q;
    reg [1:0] res_q;
    reg commit_q;
    reg [7:0] duty_q;
    reg falling_q;
    reg [11:0] wait_q;
    reg dwelling_q;
    reg [7:0] top;
    reg [4:0] step;
    reg [3:0] field;
    reg [2:0] seg;
    reg [8:0] sum;
    reg [8:0] sub;
    reg [7:0] up_duty;
    reg [7:0] down_duty;
    reg [31:0] rd_d;
    wire [7:0] pwm_cnt;
    wire run;
    wire wr_bounds;
    wire wr_dwell;
    wire wr_steps;
    wire wr_ctrl;
    wire [7:0] upper;
    wire [7:0] lower;
    wire [11:0] top_dwell;
    wire [11:0] bot_dwell;
    wire at_upper;
    wire at_lower;
    wire pend;

    assign wr_bounds = wr_in && (addr_in == `LBRC_OFF_BOUNDS);
    assign wr_dwell = wr_in && (addr_in == `LBRC_OFF_DWELL);
    assign wr_steps = wr_in && (addr_in == `LBRC_OFF_STEPS);
    assign wr_ctrl = wr_in && (addr_in == `LBRC_OFF_CTRL);
    assign upper = bounds_q[`LBRC_UPPER_MSB:`LBRC_UPPER_LSB];
    assign lower = bounds_q[`LBRC_LOWER_MSB:`LBRC_LOWER_LSB];
    assign top_dwell = dwell_q[`LBRC_TOP_MSB:`LBRC_TOP_LSB];
    assign bot_dwell = dwell_q[`LBRC_BOT_MSB:`LBRC_BOT_LSB];
    assign run = (mode_q == `LBRC_MODE_BREATHE) || (mode_q == `LBRC_MODE_BLINK);

    lbrc_pwm_period u_period (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .run_in(run),
        .res_in(res_q),
        .prescale_in(bot_dwell),
        .use_prescale_in(mode_q == `LBRC_MODE_BLINK),
        .period_end_out(pend),
        .count_out(pwm_cnt)
    );
    assign period_end_out = pend;

    // Range top per resolution
    always @*
    begin
        case (res_q)
            `LBRC_RES_7: top = 8'h7F;
            `LBRC_RES_6: top = 8'h3F;
            default: top = 8'hFF;
        endcase
    end

    // Segment index and step size
    always @*
    begin
        if (mirror_q)
        begin
            seg = duty_q[7:5];
        end
        else
        begin
            seg = {falling_q, duty_q[7:6]};
        end
        field = steps_q[{seg, 2'b00} +: 4];
        case (res_q)
            `LBRC_RES_7: step = {2'b00, field[3:1]} + 5'h01;
            `LBRC_RES_6: step = {3'b000, field[3:2]} + 5'h01;
            default: step = {1'b0, field} + 5'h01;
        endcase
    end

    assign at_upper = duty_q >= upper;
    assign at_lower = duty_q <= lower;

    // Bounds holding register with byte lanes
    always @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            bounds_hold_q <= `LBRC_BOUNDS_RST;
            bounds_q <= `LBRC_BOUNDS_RST;
        end
        else
        begin
            if (wr_bounds && wbe_in[1])
            begin
                bounds_hold_q[15:8] <= wdata_in[15:8];
            end
            if (wr_bounds && wbe_in[0])
            begin
                bounds_hold_q[7:0] <= wdata_in[7:0];
            end
            if (pend)
            begin
                bounds_q <= bounds_hold_q;
            end
        end
    end

    // Dwell and step holding registers, commit and control
    always @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            dwell_hold_q <= `LBRC_DWELL_RST;
            dwell_q <= `LBRC_DWELL_RST;
            steps_hold_q <= `LBRC_STEPS_RST;
            steps_q <= `LBRC_STEPS_RST;
            mode_q <= `LBRC_MODE_OFF;
            mirror_q <= 1'b0;
            res_q <= `LBRC_RES_8;
            commit_q <= 1'b0;
        end
        else
        begin
            if (wr_dwell)
            begin
                dwell_hold_q <= wdata_in[23:0];
            end
            if (wr_steps)
            begin
                steps_hold_q <= wdata_in;
            end
            if (wr_ctrl)
            begin
                mode_q <= wdata_in[`LBRC_CTRL_MODE_MSB:`LBRC_CTRL_MODE_LSB];
                mirror_q <= wdata_in[`LBRC_CTRL_MIRROR];
                res_q <= wdata_in[`LBRC_CTRL_RES_MSB:`LBRC_CTRL_RES_LSB];
            end
            if (pend && commit_q)
            begin
                dwell_q <= dwell_hold_q;
                steps_q <= steps_hold_q;
            end
            // Software set wins over hardware clear
            if (wr_ctrl && wdata_in[`LBRC_CTRL_COMMIT])
            begin
                commit_q <= 1'b1;
            end
            else if (pend && commit_q)
            begin
                commit_q <= 1'b0;
            end
        end
    end

    // Next duty in either direction, clipped to the resolution range
    always @*
    begin
        sum = {1'b0, duty_q} + {4'h0, step};
        sub = {1'b0, duty_q} - {4'h0, step};
        if (sum > {1'b0, top})
        begin
            up_duty = top;
        end
        else
        begin
            up_duty = sum[7:0];
        end
        if (sub[8])
        begin
            down_duty = 8'h00;
        end
        else
        begin
            down_duty = sub[7:0];
        end
    end

    // Breathing state machine on period ends
    // The period that spots the bound is not a dwell period; the dwell periods follow it

    always @(posedge core_clk_in)
    begin
        if (!nrst_in || mode_q == `LBRC_MODE_OFF)
        begin
            duty_q <= 8'h00;
            falling_q <= 1'b0;
            wait_q <= 12'h000;
            dwelling_q <= 1'b0;
        end
        else if (pend && mode_q == `LBRC_MODE_BREATHE)
        begin
            if (dwelling_q)
            begin
                if (wait_q == 12'h000)
                begin
                    dwelling_q <= 1'b0;
                    falling_q <= !falling_q;
                    duty_q <= falling_q ? up_duty : down_duty;
                end
                else
                begin
                    wait_q <= wait_q - 12'h001;
                end
            end
            else if (!falling_q && at_upper)
            begin
                if (top_dwell == 12'h000)
                begin
                    falling_q <= 1'b1;
                    duty_q <= down_duty;
                end
                else
                begin
                    dwelling_q <= 1'b1;
                    wait_q <= top_dwell - 12'h001;
                end
            end
            else if (falling_q && at_lower)
            begin
                if (bot_dwell == 12'h000)
                begin
                    falling_q <= 1'b0;
                    duty_q <= up_duty;
                end
                else
                begin
                    dwelling_q <= 1'b1;
                    wait_q <= bot_dwell - 12'h001;
                end
            end
            else if (falling_q)
            begin
                duty_q <= down_duty;
            end
            else
            begin
                duty_q <= up_duty;
            end
        end
    end

    assign falling_out = falling_q;

    // Output level and effective duty
    always @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            pwm_out <= 1'b0;
            duty_out <= 8'h00;
        end
        else
        begin
            case (mode_q)
                `LBRC_MODE_BREATHE:
                begin
                    pwm_out <= pwm_cnt < duty_q;
                    duty_out <= duty_q;
                end
                `LBRC_MODE_BLINK:
                begin
                    pwm_out <= pwm_cnt < lower;
                    duty_out <= lower;
                end
                `LBRC_MODE_ON:
                begin
                    pwm_out <= 1'b1;
                    duty_out <= top;
                end
                default:
                begin
                    pwm_out <= 1'b0;
                    duty_out <= 8'h00;
                end
            endcase
        end
    end

    // Read mux, data stand one cycle after the strobe
    always @*
    begin
        case (addr_in)
            `LBRC_OFF_CTRL: rd_d = {25'h0, commit_q, res_q, 1'b0, mirror_q, mode_q};
            `LBRC_OFF_BOUNDS: rd_d = {16'h0000, bounds_q};
            `LBRC_OFF_DWELL: rd_d = {8'h00, dwell_q};
            `LBRC_OFF_STEPS: rd_d = steps_q;
            default: rd_d = 32'h00000000;
        endcase
    end

    always @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            rdata_out <= 32'h00000000;
        end
        else
        begin
            rdata_out <= rd_in ? rd_d : 32'h00000000;
        end
    end
endmodule
